// file: verilog/fault_capture_pkg.sv
package fault_capture_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [3:0] faulting_address_offset = 4'h0;
   localparam logic [3:0] pointer_offset          = 4'h4;
   localparam logic [3:0] mask_offset             = 4'h8;
   localparam logic [3:0] config_offset           = 4'hc;
   localparam logic [3:0] irq_status_offset       = 4'h1;
   localparam logic [3:0] irq_mask_offset         = 4'h2;

   // -------------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------------
   localparam int         legacy_page_low     = 4;
   localparam int         legacy_page_high    = 22;
   localparam int         va_page_low         = 13;
   localparam int         va_shift            = 9;
   localparam logic [31:0] legacy_field_mask  = 32'h007f_fff0;
   localparam logic [31:0] required_mask      = 32'h007f_fff0;
   localparam logic [31:0] mask_reset         = 32'h007f_fff0;
   localparam logic [31:0] mask_fixed_zero    = 32'h0000_0000;
   localparam logic [31:0] mask_fixed_one     = 32'h0000_0000;
   localparam logic [31:0] word_reset         = 32'h0000_0000;
   localparam logic [1:0]  config_reset       = 2'h0;
   localparam logic [2:0]  irq_reset          = 3'h0;

   // -------------------------------------------------------------------
   // Exception cause codes presented by the pipeline
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      cause_none         = 3'b000,
      cause_load_addr    = 3'b001,
      cause_store_addr   = 3'b010,
      cause_refill       = 3'b011,
      cause_invalid      = 3'b100,
      cause_modified     = 3'b101,
      cause_other        = 3'b110,
      cause_dup_write    = 3'b111
   } cause_t;

   // Interrupt status bits.
   localparam int irq_addr_bit  = 0;
   localparam int irq_xlat_bit  = 1;
   localparam int irq_dup_bit   = 2;

endpackage

// file: verilog/tlb_fault_address_capture.sv
// Operation
// - Duplicate translation entry writes never raise a machine check.
// - Faulting-address register is read-only, 32 bits, last faulting address.
// - Loaded only on address error, refill, invalid and modified exceptions.
// - Table base field is plain software storage, untouched by hardware.
// - Legacy mode: translation faults write VA 31..13 into pointer 22:4.
// - After address error the faulting page field is undefined.
// - Extended mode: VA X+8:Y+9 written into pointer X-1:Y per mask.
// - Extended mode: pointer bits above the mask stay software read/write.
// - Extended mode: pointer bits below the lowest mask bit read zero.
// - Changing the mask leaves pointer contents unpredictable until rewritten.
// - All-ones mask copies the full faulting address into the pointer.
// - All-zeroes mask leaves every pointer bit software read/write.
// - Mask presence is reported by either extended configuration flag.
// - Some mask bits may be fixed; software probes with zeroes and ones.
// - Mask must accept the 4K page, 64-bit entry single-level value.
// - Translation faults also load the staging register page-pair field.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module tlb_fault_address_capture #(
   parameter logic [31:0] mask_fixed_zero = fault_capture_pkg::mask_fixed_zero,
   parameter logic [31:0] mask_fixed_one  = fault_capture_pkg::mask_fixed_one
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // Exception entry from the pipeline.
   input  wire logic        exc_valid,
   input  wire logic [2:0]  exc_cause,
   input  wire logic [31:0] exc_vaddr,
   // Register port.
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // Staging register page-pair load.
   output logic             page_pair_load,
   output logic      [18:0] page_pair,
   // Configuration flags and interrupt.
   output logic             pointer_config_present_flag,
   output logic             smart_pointer_flag,
   output logic             irq
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] faulting_virtual_address;
      logic [31:0] page_table_entry_pointer;
      logic [31:0] pointer_field_mask;
      logic [1:0]  cfg;
      logic [2:0]  irq_status;
      logic [2:0]  irq_mask;
      logic [31:0] rdata;
      logic        page_pair_load;
      logic [18:0] page_pair;
      logic        irq;
   } state_t;

   state_t st;
   state_t next_st;

   // Every bit below the lowest set bit, used for read masking.
   function automatic logic [31:0] below_lowest(input logic [31:0] m);
      logic [31:0] low;
      low = m & (~m + 32'h0000_0001);
      below_lowest = (m == 32'h0000_0000) ? 32'h0000_0000
                     : (low - 32'h0000_0001);
   endfunction

   // Virtual address aligned so that VA bit n+9 lands on pointer bit n.
   function automatic logic [31:0] shifted_va(input logic [31:0] va,
                                              input logic [31:0] m);
      logic [31:0] s;
      s = va >> fault_capture_pkg::va_shift;
      // A full mask mirrors the faulting address unshifted.
      shifted_va = (m == 32'hffff_ffff) ? va : s;
   endfunction

   logic        extended;
   logic        is_addr_err;
   logic        is_xlat;
   logic [31:0] eff_mask;
   logic [31:0] ptr_view;
   logic [31:0] new_mask;

   always_comb begin
      next_st = st;
      extended = st.cfg[0] | st.cfg[1];
      eff_mask = extended ? st.pointer_field_mask
                          : fault_capture_pkg::legacy_field_mask;
      is_addr_err = exc_valid &&
         (exc_cause == fault_capture_pkg::cause_load_addr ||
          exc_cause == fault_capture_pkg::cause_store_addr);
      is_xlat = exc_valid &&
         (exc_cause == fault_capture_pkg::cause_refill ||
          exc_cause == fault_capture_pkg::cause_invalid ||
          exc_cause == fault_capture_pkg::cause_modified);
      // In extended mode, bits below the lowest mask bit read as zero.
      ptr_view = extended
         ? (st.page_table_entry_pointer & ~below_lowest(eff_mask))
         : st.page_table_entry_pointer;
      new_mask = (wdata | mask_fixed_one) & ~mask_fixed_zero;

      next_st.page_pair_load = 1'b0;

      // Software writes; the table base field is plain storage.
      if (wr) begin
         unique case (addr)
            fault_capture_pkg::pointer_offset: begin
               next_st.page_table_entry_pointer = wdata;
            end
            fault_capture_pkg::mask_offset: begin
               // The pointer is left as is; its meaning is unpredictable
               // until software rewrites it or a fault reloads it.
               next_st.pointer_field_mask = new_mask;
            end
            fault_capture_pkg::config_offset: begin
               next_st.cfg = wdata[1:0];
            end
            fault_capture_pkg::irq_mask_offset: begin
               next_st.irq_mask = wdata[2:0];
            end
            fault_capture_pkg::irq_status_offset: begin
               next_st.irq_status = st.irq_status & ~wdata[2:0];
            end
            default: begin
            end
         endcase
      end

      // A translation fault loads both registers in the same cycle; an address error loads only the faulting address.
      if (is_addr_err || is_xlat) begin
         next_st.faulting_virtual_address = exc_vaddr;
      end
      // A fault in the same cycle as a pointer write overrides the
      // written value in the bits that the fault owns.
      if (is_xlat) begin
         // Only the masked bits change; bits above stay with software.
         next_st.page_table_entry_pointer =
            (next_st.page_table_entry_pointer & ~eff_mask) |
            (shifted_va(exc_vaddr, eff_mask) & eff_mask);
         next_st.page_pair_load = 1'b1;
         next_st.page_pair = exc_vaddr[31:fault_capture_pkg::va_page_low];
      end
      // An address error leaves the faulting page field as it was.

      // Duplicate entry writes are accepted with no fault; just noted.
      if (exc_valid && exc_cause == fault_capture_pkg::cause_dup_write) begin
         next_st.irq_status[fault_capture_pkg::irq_dup_bit] = 1'b1;
      end
      if (is_addr_err) begin
         next_st.irq_status[fault_capture_pkg::irq_addr_bit] = 1'b1;
      end
      if (is_xlat) begin
         next_st.irq_status[fault_capture_pkg::irq_xlat_bit] = 1'b1;
      end

      // Read data, one cycle after the strobe.
      next_st.rdata = 32'h0000_0000;
      if (rd) begin
         unique case (addr)
            fault_capture_pkg::faulting_address_offset: begin
               next_st.rdata = st.faulting_virtual_address;
            end
            fault_capture_pkg::pointer_offset: begin
               next_st.rdata = ptr_view;
            end
            fault_capture_pkg::mask_offset: begin
               next_st.rdata = st.pointer_field_mask;
            end
            fault_capture_pkg::config_offset: begin
               next_st.rdata = {30'h0000_0000, st.cfg};
            end
            fault_capture_pkg::irq_mask_offset: begin
               next_st.rdata = {29'h0000_0000, st.irq_mask};
            end
            fault_capture_pkg::irq_status_offset: begin
               next_st.rdata = {29'h0000_0000, st.irq_status};
            end
            default: begin
            end
         endcase
      end

      // The interrupt follows the next status and mask, so it rises in
      // the same cycle as the status bit that raises it.
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st                    <= '0;
         st.pointer_field_mask <= fault_capture_pkg::mask_reset;
      end else begin
         st <= next_st;
      end
   end

   assign rdata                       = st.rdata;
   assign page_pair_load              = st.page_pair_load;
   assign page_pair                   = st.page_pair;
   assign pointer_config_present_flag = st.cfg[0];
   assign smart_pointer_flag          = st.cfg[1];
   assign irq                         = st.irq;

   // -------------------------------------------------------------------
   // Checks: faulting address and read data
   // -------------------------------------------------------------------
   fault_load_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_addr_err || is_xlat) |=> st.faulting_virtual_address ==
         $past(exc_vaddr)) else $error("fault address not captured");

   fault_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(is_addr_err || is_xlat) |=> $stable(st.faulting_virtual_address))
      else $error("fault address changed without fault");

   fault_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == fault_capture_pkg::faulting_address_offset) |=>
         rdata == $past(st.faulting_virtual_address))
      else $error("fault address read wrong");

   other_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      (exc_valid && !wr && exc_cause == fault_capture_pkg::cause_other) |=>
         ($stable(st.faulting_virtual_address) && !page_pair_load &&
          $stable(st.page_table_entry_pointer)))
      else $error("unrelated exception changed a register");

   dup_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      (exc_valid && exc_cause == fault_capture_pkg::cause_dup_write) |=>
         ($stable(st.faulting_virtual_address) && !page_pair_load &&
          st.irq_status[fault_capture_pkg::irq_dup_bit]))
      else $error("duplicate write raised a fault");

   rdata_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> rdata == 32'h0000_0000)
      else $error("read data outside read cycle");

   status_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == fault_capture_pkg::irq_status_offset) |=>
         rdata == {29'h0000_0000, $past(st.irq_status)})
      else $error("status read wrong");

   mask_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == fault_capture_pkg::mask_offset) |=>
         rdata == $past(st.pointer_field_mask))
      else $error("mask read wrong");

   // -------------------------------------------------------------------
   // Checks: pointer register and page pair
   // -------------------------------------------------------------------
   legacy_page_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_xlat && !extended) |=> st.page_table_entry_pointer[22:4] ==
         $past(exc_vaddr[31:13])) else $error("legacy page wrong");

   legacy_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (rd && !extended &&
       addr == fault_capture_pkg::pointer_offset) |=>
         rdata == $past(st.page_table_entry_pointer))
      else $error("legacy pointer read wrong");

   ext_field_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_xlat && extended && st.pointer_field_mask != 32'hffff_ffff) |=>
         (st.page_table_entry_pointer & $past(eff_mask)) ==
         (($past(exc_vaddr) >> fault_capture_pkg::va_shift) &
          $past(eff_mask)))
      else $error("extended page field wrong");

   upper_keep_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_xlat && !wr) |=>
         (((st.page_table_entry_pointer ^ $past(st.page_table_entry_pointer))
          & ~$past(eff_mask)) == 32'h0000_0000))
      else $error("pointer bits outside the mask changed");

   base_keep_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_xlat && !wr && !extended) |=>
         st.page_table_entry_pointer[31:23] ==
         $past(st.page_table_entry_pointer[31:23]))
      else $error("base field altered");

   zero_mask_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_xlat && !wr && extended && st.pointer_field_mask == 32'h0000_0000)
      |=> $stable(st.page_table_entry_pointer))
      else $error("zero mask pointer changed");

   full_mask_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_xlat && extended && st.pointer_field_mask == 32'hffff_ffff) |=>
         st.page_table_entry_pointer == st.faulting_virtual_address)
      else $error("full mask mismatch");

   addr_err_a: assert property (@(posedge clk) disable iff (!rstn)
      (is_addr_err && !wr) |=>
         $stable(st.page_table_entry_pointer))
      else $error("address error moved pointer");

   ptr_low_a: assert property (@(posedge clk) disable iff (!rstn)
      (rd && extended &&
       addr == fault_capture_pkg::pointer_offset) |=>
         (rdata & $past(below_lowest(eff_mask))) == 32'h0000_0000)
      else $error("pointer bits below the mask read nonzero");

   ptr_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && !is_xlat && addr == fault_capture_pkg::pointer_offset) |=>
         st.page_table_entry_pointer == $past(wdata))
      else $error("pointer write not taken");

   mask_ptr_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && !is_xlat && addr == fault_capture_pkg::mask_offset) |=>
         $stable(st.page_table_entry_pointer))
      else $error("mask write moved pointer");

   pair_load_a: assert property (@(posedge clk) disable iff (!rstn)
      is_xlat |=> page_pair_load && page_pair == $past(exc_vaddr[31:13]))
      else $error("page pair not loaded");

   pair_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      !is_xlat |=> (!page_pair_load && $stable(page_pair)))
      else $error("page pair moved without fault");

   // -------------------------------------------------------------------
   // Checks: mask and configuration
   // -------------------------------------------------------------------
   mask_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && addr == fault_capture_pkg::mask_offset) |=>
         st.pointer_field_mask ==
         (($past(wdata) | mask_fixed_one) & ~mask_fixed_zero))
      else $error("mask write not taken");

   mask_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(wr && addr == fault_capture_pkg::mask_offset) |=>
         $stable(st.pointer_field_mask))
      else $error("mask changed without a write");

   mask_reset_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> st.pointer_field_mask == fault_capture_pkg::mask_reset)
      else $error("mask reset value wrong");

   flag_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && addr == fault_capture_pkg::config_offset) |=>
         ({smart_pointer_flag, pointer_config_present_flag} ==
          $past(wdata[1:0])))
      else $error("configuration flags not taken");

   cfg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(wr && addr == fault_capture_pkg::config_offset) |=>
         $stable({smart_pointer_flag, pointer_config_present_flag}))
      else $error("flags changed without a write");

   // -------------------------------------------------------------------
   // Checks: status and interrupt
   // -------------------------------------------------------------------
   irq_level_a: assert property (@(posedge clk) disable iff (!rstn)
      irq == |(st.irq_status & st.irq_mask))
      else $error("interrupt level wrong");

   irq_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && !exc_valid &&
       addr == fault_capture_pkg::irq_status_offset) |=>
         (st.irq_status & $past(wdata[2:0])) == 3'h0)
      else $error("status bits not cleared");

   irq_set_a: assert property (@(posedge clk) disable iff (!rstn)
      is_xlat |=> st.irq_status[fault_capture_pkg::irq_xlat_bit])
      else $error("translation status not set");

   addr_status_a: assert property (@(posedge clk) disable iff (!rstn)
      is_addr_err |=> st.irq_status[fault_capture_pkg::irq_addr_bit])
      else $error("address error status not set");

   irq_mask_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr && addr == fault_capture_pkg::irq_mask_offset) |=>
         st.irq_mask == $past(wdata[2:0]))
      else $error("interrupt mask not taken");

endmodule

// file: testbench/tlb_fault_address_capture_tb.sv
`timescale 1ns/1ns
module tlb_fault_address_capture_tb;
   logic        clk;
   logic        rstn;
   logic        exc_valid;
   logic [2:0]  exc_cause;
   logic [31:0] exc_vaddr;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        page_pair_load;
   logic [18:0] page_pair;
   logic        present_flag;
   logic        smart_flag;
   logic        irq;
   int          fail_count;
   int          check_count;
   logic [31:0] ptr;
   logic [31:0] va;
   logic [31:0] masks [4];
   logic        exp_irq;

   tlb_fault_address_capture DUT (
      .clk                         (clk),
      .rstn                        (rstn),
      .exc_valid                   (exc_valid),
      .exc_cause                   (exc_cause),
      .exc_vaddr                   (exc_vaddr),
      .addr                        (addr),
      .wdata                       (wdata),
      .wr                          (wr),
      .rd                          (rd),
      .rdata                       (rdata),
      .page_pair_load              (page_pair_load),
      .page_pair                   (page_pair),
      .pointer_config_present_flag (present_flag),
      .smart_pointer_flag          (smart_flag),
      .irq                         (irq)
   );

   // ----------------------------------------------------------------
   // Bus tasks and expectations
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask

   task automatic raise(input logic [2:0] c, input logic [31:0] v,
                        input logic xl);
      @(posedge clk);
      exc_valid <= 1'b1;
      exc_cause <= c;
      exc_vaddr <= v;
      @(posedge clk);
      exc_valid <= 1'b0;
      #1;
      chk("page_pair_load", {31'h0, xl}, {31'h0, page_pair_load});
      if (xl) chk("page_pair", {13'h0, v[31:13]}, {13'h0, page_pair});
      chk("irq", {31'h0, exp_irq}, {31'h0, irq});
   endtask

   // Bits that survive a read: everything at or above the lowest mask bit.
   function automatic logic [31:0] keep_bits(input logic [31:0] mk);
      return (mk == 32'h0000_0000) ? 32'hffff_ffff : ~((mk & -mk) - 1);
   endfunction

   function automatic logic [31:0] after(input logic [31:0] p,
                                         input logic [31:0] mk,
                                         input logic [31:0] v);
      logic [31:0] src;
      src = (mk == 32'hffff_ffff) ? v : v >> 9;
      return ((p & ~mk) | (src & mk)) & keep_bits(mk);
   endfunction

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      #2_000_000;
      fail_count++;
      end_sim;
   end

   initial begin
      rstn = 1'b0; exc_valid = 1'b0; exc_cause = 3'h0; exc_vaddr = 32'h0;
      addr = 4'h0; wdata = 32'h0000_0000; wr = 1'b0; rd = 1'b0;
      fail_count = 0; check_count = 0; exp_irq = 1'b0;
      masks = '{32'h003f_fff8, 32'hffff_ffff, 32'h0000_0000, 32'h000f_fff8};
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(4'h8, 32'h007f_fff0);
      rd_reg(4'hc, 32'h0000_0000);
      $display("test reset done");
      ptr = 32'ha500_0000;
      wr_reg(4'h4, ptr);
      for (int c = 3; c <= 5; c++) begin
         va = 32'h1234_5678 ^ (c << 24);
         raise(c[2:0], va, 1'b1);
         rd_reg(4'h0, va);
         ptr = after(ptr, 32'h007f_fff0, va);
         rd_reg(4'h4, ptr);
      end
      $display("test legacy done");
      raise(fault_capture_pkg::cause_load_addr, 32'h8000_1001, 1'b0);
      rd_reg(4'h0, 32'h8000_1001);
      raise(fault_capture_pkg::cause_store_addr, 32'h0040_2002, 1'b0);
      rd_reg(4'h0, 32'h0040_2002);
      raise(fault_capture_pkg::cause_other, 32'hdead_0000, 1'b0);
      raise(fault_capture_pkg::cause_dup_write, 32'hbeef_0000, 1'b0);
      wr_reg(4'h0, 32'h0bad_0000);
      rd_reg(4'h0, 32'h0040_2002);
      rd_reg(4'h1, 32'h0000_0007);
      $display("test address error done");
      for (int k = 2; k >= 1; k--) begin
         wr_reg(4'hc, k);
         rd_reg(4'hc, k);
         chk("flags", k, {30'h0, smart_flag, present_flag});
      end
      wr_reg(4'h8, 32'h0000_0000);
      rd_reg(4'h8, 32'h0000_0000);
      wr_reg(4'h8, 32'hffff_ffff);
      rd_reg(4'h8, 32'hffff_ffff);
      wr_reg(4'h8, 32'h007f_fff0);
      rd_reg(4'h8, 32'h007f_fff0);
      $display("test mask probe done");
      foreach (masks[i]) begin
         va = 32'h9abc_def1 ^ (i << 28);
         wr_reg(4'h8, masks[i]);
         wr_reg(4'h4, 32'hffff_ffff);
         ptr = keep_bits(masks[i]);
         rd_reg(4'h4, ptr);
         raise(fault_capture_pkg::cause_refill, va, 1'b1);
         rd_reg(4'h4, after(ptr, masks[i], va));
         rd_reg(4'h0, va);
      end
      $display("test extended done");
      wr_reg(4'h1, 32'h0000_0007);
      rd_reg(4'h1, 32'h0000_0000);
      wr_reg(4'h2, 32'h0000_0001);
      rd_reg(4'h2, 32'h0000_0001);
      exp_irq = 1'b1;
      raise(fault_capture_pkg::cause_store_addr, 32'h0000_3004, 1'b0);
      rd_reg(4'h1, 32'h0000_0001);
      wr_reg(4'h1, 32'h0000_0001);
      #1;
      exp_irq = 1'b0;
      chk("irq", 32'h0000_0000, {31'h0, irq});
      raise(fault_capture_pkg::cause_dup_write, 32'h0000_5000, 1'b0);
      rd_reg(4'h1, 32'h0000_0004);
      $display("test interrupt done");
      end_sim;
   end
endmodule
